// ---- verilog/lcd_ctl.sv ----
// segment lcd control: registers, clock choice, prescalers, ladder power
// assumes oscillator inputs already synchronous to REF_CLK
//
// What this block does
// R1: contrast code sets ladder resistance sevenths
// R2: contrast bits 7..3 read zero
// R3: segment enable bit gives pin to driver
// R4: pixel bits survive all clocked resets
// R5: clock from fosc/256, crystal or internal
// R6: fosc divide by 256 is fixed
// R7: software enables crystal before selecting it
// R8: oscillator sources keep running during sleep
// R9: 4-bit frame prescaler divides 1 to 16
// R10: static, half and third bias modes
// R11: half bias shorts middle ladder resistor
// R12: ladder low, medium, high or off
// R13: ladder off while module inactive
// R14: mode A after transition, then mode B
// R15: duration field sets mode A length
// R16: mode A timed by 5-bit base prescaler
// R17: ladder register holds A, B, duration
// R18: power codes off, low, medium, high
// R19: duration restarts each frame transition
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module lcd_ctl
    import lcd_ctl_pkg::*;
#(
    parameter int SEG_REGS = 8,
    parameter int PIX_REGS = 32
)(
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic [7:0] BUS_ADDR,
    input wire logic [7:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [7:0] BUS_RDATA,
    input wire logic SLEEP,
    input wire logic XTAL_CLK_IN,
    input wire logic LFINT_CLK_IN,
    output logic [2:0] CONTRAST_SEL,
    output logic [SEG_REGS*8-1:0] SEG_PIN_ENABLE,
    output logic [PIX_REGS*8-1:0] PIXEL_ON,
    output logic [1:0] LADDER_POWER,
    output logic MID_SHORT,
    output logic [1:0] BIAS_MODE,
    output logic FRAME_TICK,
    output logic MODE_A_ACTIVE,
    output logic MODULE_ACTIVE
);
    // whole module state
    typedef struct packed {
        logic [2:0] cst; // contrast code
        logic en; // module enable
        logic [1:0] cs; // clock source
        logic [1:0] bias; // bias mode
        logic [3:0] lp; // frame prescale
        logic [1:0] lad_a; // mode A power
        logic [1:0] lad_b; // mode B power
        logic [2:0] dur; // mode A duration
        logic [SEG_REGS-1:0][7:0] seg; // segment enables
        logic [PIX_REGS-1:0][7:0] pix; // pixel bits
        logic [2:0] prediv; // system clock predivider
        logic [4:0] base; // 5-bit base prescaler
        logic [3:0] fcnt; // 4-bit frame prescaler
        logic xprev; // crystal input last value
        logic lprev; // internal osc last value
        logic mode_a; // mode A phase
        logic ftick; // frame transition pulse
        logic [1:0] ladder; // driven ladder power
        logic mid; // middle resistor short
        logic act; // module active flag
        logic [7:0] rdata; // read data
    } state_t;

    state_t st; // registered state
    state_t next_st; // next state
    logic src_tick; // one tick of selected source
    logic base_tick; // base prescaler wrap
    logic run; // timing allowed to advance

    // assertion clock and reset for the whole module
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    // true when addr lies in a bank of n registers from base
    function automatic logic in_bank(input logic [7:0] addr, input logic [7:0] base, input int n);
        in_bank = (addr >= base) && (int'(addr - base) < n);
    endfunction

    // source tick and base tick
    always_comb
    begin
        case (st.cs)
            CS_XTAL: src_tick = XTAL_CLK_IN & ~st.xprev; // [R5]
            CS_LFINT: src_tick = LFINT_CLK_IN & ~st.lprev; // [R5]
            default: src_tick = (st.prediv == PREDIV_LAST); // [R6]
        endcase
        // system clock stops in sleep, oscillators go on
        // code 3 runs from fosc too, so it stops as well
        run = st.en && !(SLEEP && st.cs != CS_XTAL && st.cs != CS_LFINT); // [R8]
        base_tick = run && src_tick && (st.base == BASE_LAST);
    end

    // next state
    always_comb
    begin
        next_st = st;
        next_st.xprev = XTAL_CLK_IN;
        next_st.lprev = LFINT_CLK_IN;
        next_st.prediv = st.prediv + 3'h1; // fixed, not writable [R6]
        next_st.ftick = 1'b0;
        next_st.rdata = 8'h00;
        if (run && src_tick)
        begin
            next_st.base = st.base + 5'h01; // [R16]
        end
        if (base_tick)
        begin
            // divide by lp + 1 [R9]
            if (st.fcnt >= st.lp)
            begin
                next_st.fcnt = 4'h0;
                next_st.ftick = 1'b1;
            end
            else
            begin
                next_st.fcnt = st.fcnt + 4'h1;
            end
        end
        // mode A restarts at each transition, zero means never [R14] [R15] [R19]
        if (st.ftick)
        begin
            next_st.mode_a = (st.dur != 3'h0);
        end
        else if (st.base > {2'h0, st.dur})
        begin
            next_st.mode_a = 1'b0; // [R16] [R19]
        end
        if (!st.en)
        begin
            next_st.mode_a = 1'b0;
            next_st.fcnt = 4'h0;
            next_st.base = 5'h00;
        end
        next_st.act = st.en;
        // ladder power with forced off [R12] [R13] [R18]
        if (!st.act)
        begin
            next_st.ladder = LAD_OFF;
        end
        else if (st.mode_a)
        begin
            next_st.ladder = st.lad_a; // [R14]
        end
        else
        begin
            next_st.ladder = st.lad_b; // [R14]
        end
        next_st.mid = (st.bias == BIAS_HALF); // [R10] [R11]
        // register writes
        if (BUS_WR)
        begin
            if (BUS_ADDR == A_CONTRAST)
            begin
                next_st.cst = BUS_WDATA[2:0]; // [R1]
            end
            else if (BUS_ADDR == A_DISPCTL)
            begin
                next_st.en = BUS_WDATA[DC_EN];
                next_st.bias = BUS_WDATA[DC_BIAS+:2]; // [R10]
                next_st.cs = BUS_WDATA[DC_CS+:2]; // [R5]
            end
            else if (BUS_ADDR == A_PRESCALE)
            begin
                next_st.lp = BUS_WDATA[3:0]; // [R9]
            end
            else if (BUS_ADDR == A_LADDER)
            begin
                next_st.lad_a = BUS_WDATA[LR_A+:2]; // [R17]
                next_st.lad_b = BUS_WDATA[LR_B+:2]; // [R17]
                next_st.dur = BUS_WDATA[LR_DUR+:3]; // [R17]
            end
            else if (in_bank(BUS_ADDR, A_SEGEN, SEG_REGS))
            begin
                next_st.seg[BUS_ADDR - A_SEGEN] = BUS_WDATA; // [R3]
            end
            else if (in_bank(BUS_ADDR, A_PIXEL, PIX_REGS))
            begin
                next_st.pix[BUS_ADDR - A_PIXEL] = BUS_WDATA; // [R4]
            end
        end
        // register reads, data next cycle, unmapped read zero
        if (BUS_RD)
        begin
            if (BUS_ADDR == A_CONTRAST)
            begin
                next_st.rdata = {5'h00, st.cst}; // [R2]
            end
            else if (BUS_ADDR == A_DISPCTL)
            begin
                next_st.rdata = {st.en, st.act, 2'h0, st.bias, st.cs};
            end
            else if (BUS_ADDR == A_PRESCALE)
            begin
                next_st.rdata = {4'h0, st.lp};
            end
            else if (BUS_ADDR == A_LADDER)
            begin
                next_st.rdata = {st.lad_a, st.lad_b, 1'b0, st.dur}; // [R17]
            end
            else if (in_bank(BUS_ADDR, A_SEGEN, SEG_REGS))
            begin
                next_st.rdata = st.seg[BUS_ADDR - A_SEGEN];
            end
            else if (in_bank(BUS_ADDR, A_PIXEL, PIX_REGS))
            begin
                next_st.rdata = st.pix[BUS_ADDR - A_PIXEL];
            end
        end
        // reset all but pixel data
        if (SYS_RST)
        begin
            next_st.cst = RST_CONTRAST[2:0];
            next_st.en = RST_DISPCTL[DC_EN];
            next_st.cs = RST_DISPCTL[DC_CS+:2];
            next_st.bias = RST_DISPCTL[DC_BIAS+:2];
            next_st.lp = RST_PRESCALE[3:0];
            next_st.lad_a = RST_LADDER[LR_A+:2];
            next_st.lad_b = RST_LADDER[LR_B+:2];
            next_st.dur = RST_LADDER[LR_DUR+:3];
            next_st.seg = {SEG_REGS{RST_SEGEN}};
            next_st.pix = st.pix; // kept across reset [R4]
            next_st.prediv = 3'h0;
            next_st.base = 5'h00;
            next_st.fcnt = 4'h0;
            next_st.xprev = 1'b0;
            next_st.lprev = 1'b0;
            next_st.mode_a = 1'b0;
            next_st.ftick = 1'b0;
            next_st.ladder = LAD_OFF;
            next_st.mid = 1'b0;
            next_st.act = 1'b0;
            next_st.rdata = 8'h00;
        end
    end

    // state register
    always_ff @(posedge REF_CLK)
    begin
        st <= next_st;
    end

    // outputs straight from flops
    assign BUS_RDATA = st.rdata;
    assign CONTRAST_SEL = st.cst; // [R1]
    assign SEG_PIN_ENABLE = st.seg; // [R3]
    assign PIXEL_ON = st.pix; // [R4]
    assign LADDER_POWER = st.ladder; // [R18]
    assign MID_SHORT = st.mid; // [R11]
    assign BIAS_MODE = st.bias; // [R10]
    assign FRAME_TICK = st.ftick;
    assign MODE_A_ACTIVE = st.mode_a;
    assign MODULE_ACTIVE = st.act;

    // checks

    property p_cst_read;
        BUS_RD && BUS_ADDR == A_CONTRAST |=> BUS_RDATA[7:3] == 5'h00 && BUS_RDATA[2:0] == CONTRAST_SEL;
    endproperty
    a_cst_read: assert property (p_cst_read) else $error("contrast read wrong"); // [R2]
    property p_cst_write;
        BUS_WR && BUS_ADDR == A_CONTRAST |=> CONTRAST_SEL == $past(BUS_WDATA[2:0]);
    endproperty
    a_cst_write: assert property (p_cst_write) else $error("contrast not stored"); // [R1]
    property p_seg_write;
        BUS_WR && BUS_ADDR == A_SEGEN |=> SEG_PIN_ENABLE[7:0] == $past(BUS_WDATA);
    endproperty
    a_seg_write: assert property (p_seg_write) else $error("segment enable not stored"); // [R3]
    property p_pix_keep;
        disable iff (1'b0) SYS_RST |=> PIXEL_ON === $past(PIXEL_ON);
    endproperty
    a_pix_keep: assert property (p_pix_keep) else $error("pixel lost on reset"); // [R4]
    property p_off;
        !MODULE_ACTIVE |=> LADDER_POWER == LAD_OFF;
    endproperty
    a_off: assert property (p_off) else $error("ladder on while inactive"); // [R13]
    property p_mode_pwr;
        MODULE_ACTIVE && !$past(SYS_RST) |=> LADDER_POWER == $past(MODE_A_ACTIVE ? st.lad_a : st.lad_b);
    endproperty
    a_mode_pwr: assert property (p_mode_pwr) else $error("ladder power mismatch"); // [R14]
    property p_never_a;
        st.dur == 3'h0 && FRAME_TICK |=> !MODE_A_ACTIVE;
    endproperty
    a_never_a: assert property (p_never_a) else $error("mode A with zero duration"); // [R15]
    property p_mid;
        ##1 MID_SHORT == ($past(BIAS_MODE) == BIAS_HALF);
    endproperty
    a_mid: assert property (p_mid) else $error("middle short wrong"); // [R11]
    property p_frame;
        FRAME_TICK |-> $past(base_tick) && MODULE_ACTIVE;
    endproperty
    a_frame: assert property (p_frame) else $error("frame tick without base tick"); // [R9]
    property p_sleep;
        SLEEP && st.cs == CS_FOSC && st.en |=> st.base == $past(st.base);
    endproperty
    a_sleep: assert property (p_sleep) else $error("fosc timing ran in sleep"); // [R8]
    c_frame: cover property (FRAME_TICK ##1 MODE_A_ACTIVE);
    c_modeb: cover property (MODE_A_ACTIVE ##1 !MODE_A_ACTIVE && MODULE_ACTIVE);
    c_half: cover property (MID_SHORT && MODULE_ACTIVE);
    c_xtal: cover property (st.cs == CS_XTAL && FRAME_TICK);
endmodule

// ---- include/lcd_ctl_pkg.sv ----
// constants and types for the segment lcd control block
// assumes an 8-bit register port and one system clock
package lcd_ctl_pkg;
    // register offsets
    localparam logic [7:0] A_CONTRAST = 8'h00;
    localparam logic [7:0] A_DISPCTL = 8'h01;
    localparam logic [7:0] A_PRESCALE = 8'h02;
    localparam logic [7:0] A_LADDER = 8'h03;
    localparam logic [7:0] A_SEGEN = 8'h10;
    localparam logic [7:0] A_PIXEL = 8'h40;
    // display control fields
    localparam int DC_EN = 7;
    localparam int DC_ACT = 6;
    localparam int DC_BIAS = 2;
    localparam int DC_CS = 0;
    // ladder control fields
    localparam int LR_A = 6;
    localparam int LR_B = 4;
    localparam int LR_DUR = 0;
    // reset values
    localparam logic [7:0] RST_CONTRAST = 8'h00;
    localparam logic [7:0] RST_DISPCTL = 8'h00;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [7:0] RST_LADDER = 8'h00;
    localparam logic [7:0] RST_SEGEN = 8'h00;
    // fixed dividers: system clock / 8 / 32 = / 256
    localparam logic [2:0] PREDIV_LAST = 3'h7;
    localparam logic [4:0] BASE_LAST = 5'h1F;
    // clock sources
    typedef enum logic [1:0] {CS_FOSC = 2'h0, CS_XTAL = 2'h1, CS_LFINT = 2'h2} clk_src_t;
    // bias modes
    typedef enum logic [1:0] {BIAS_STATIC = 2'h0, BIAS_HALF = 2'h1, BIAS_THIRD = 2'h2} bias_t;
    // ladder power codes
    typedef enum logic [1:0] {LAD_OFF = 2'h0, LAD_LOW = 2'h1, LAD_MED = 2'h2, LAD_HIGH = 2'h3} lad_pwr_t;
endpackage

// ---- tb/lcd_glass_model.sv ----
// behavioural glass: counts frames and notes ladder power at each one
// assumes the control block's outputs, one clock
`timescale 1ns/1ps
module lcd_glass_model
    import lcd_ctl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] ladder_power,
    input wire logic frame_tick,
    output logic [15:0] frame_count,
    output lad_pwr_t power_seen
);
    // frame counter, power level seen at each frame edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            frame_count <= 16'h0000;
            power_seen <= LAD_OFF;
        end
        else if (frame_tick)
        begin
            frame_count <= frame_count + 16'h0001;
            power_seen <= lad_pwr_t'(ladder_power);
        end
    end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the lcd control block
// assumes the package constants and the glass model
`timescale 1ns/1ps
module testbench;
    import lcd_ctl_pkg::*;
    logic ref_clk = 0, sys_rst = 1, wr = 0, rd = 0, sleep = 0, xtal = 0, lfint = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, v;
    logic [2:0] contrast;
    logic [63:0] segen;
    logic [255:0] pix;
    logic [1:0] lpow, bias;
    logic mid, tick, mode_a, active;
    logic [15:0] frames;
    lad_pwr_t seen;
    logic [3:0] ocnt = 4'h0;
    // places read back after reset, and frame prescales tried
    logic [7:0] rst_addr [6] = '{A_CONTRAST, A_DISPCTL, A_PRESCALE, A_LADDER, A_SEGEN, 8'h30};
    logic [3:0] lps [3] = '{4'h0, 4'h1, 4'hF};
    int seed, fail_count = 0, n_tests = 0, cyc = 0, n, i;
    lcd_ctl lcd_ctl_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS_ADDR(addr), .BUS_WDATA(wdata),
        .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata), .SLEEP(sleep), .XTAL_CLK_IN(xtal),
        .LFINT_CLK_IN(lfint), .CONTRAST_SEL(contrast), .SEG_PIN_ENABLE(segen), .PIXEL_ON(pix),
        .LADDER_POWER(lpow), .MID_SHORT(mid), .BIAS_MODE(bias), .FRAME_TICK(tick),
        .MODE_A_ACTIVE(mode_a), .MODULE_ACTIVE(active));
    lcd_glass_model lcd_glass_model_i (.clk(ref_clk), .rst(sys_rst), .ladder_power(lpow),
        .frame_tick(tick), .frame_count(frames), .power_seen(seen));
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    // oscillators: crystal rises every 8 clocks, internal every 16
    always @(posedge ref_clk)
    begin
        ocnt <= ocnt + 4'h1;
        xtal <= ocnt[2];
        lfint <= ocnt[3];
        cyc++;
        if (cyc == 60000)
        begin
            fail_count++;
            wrap_up;
        end
    end
    // compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle write strobe
    task wr_reg(input logic [7:0] a, input logic [7:0] dat);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= dat;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // one-cycle read strobe, data sampled the cycle after
    task rd_reg(input logic [7:0] a, output logic [7:0] dat);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        dat = rdata;
    endtask
    // cycles until the next frame tick, bounded
    task wt(input int lim, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            cnt++;
        end
        while (tick !== 1'b1 && cnt < lim);
    endtask
    // expected frame length in clocks
    function automatic int frame_len(input int lp, input int div);
        return 32 * div * (lp + 1);
    endfunction
    // verdict
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        seed = 2;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // reset values and an unmapped place
        foreach (rst_addr[k])
        begin
            rd_reg(rst_addr[k], d);
            chk(d, 8'h00);
        end
        // every contrast code, upper bits random
        for (i = 0; i < 8; i++)
        begin
            v = ($random(seed) & 8'hF8) | i;
            wr_reg(A_CONTRAST, v);
            rd_reg(A_CONTRAST, d);
            chk(d, v & 8'h07);
            chk(contrast, i);
        end
        // segment enables, random patterns
        for (i = 0; i < 8; i++)
        begin
            v = $random(seed);
            wr_reg(A_SEGEN + i, v);
            rd_reg(A_SEGEN + i, d);
            chk(d, v);
            chk(segen[8*i+:8], v);
        end
        // pixel data survives a clocked reset
        v = $random(seed);
        wr_reg(A_PIXEL + 3, v);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd_reg(A_PIXEL + 3, d);
        chk(d, v);
        chk(pix[24+:8], v);
        // bias modes
        for (i = 0; i < 4; i++)
        begin
            wr_reg(A_DISPCTL, i << 2);
            @(posedge ref_clk);
            #1;
            chk(bias, i);
            chk(mid, i == 1);
        end
        // fosc frames at several prescales, then mode A then B
        wr_reg(A_LADDER, 8'hD2);
        foreach (lps[k])
        begin
            wr_reg(A_PRESCALE, {4'h0, lps[k]});
            wr_reg(A_DISPCTL, 8'h88);
            wt(5000, n);
            wt(5000, n);
            chk(n, frame_len(lps[k], 8));
            @(posedge ref_clk);
            #1;
            chk(mode_a, 1'b1);
            @(posedge ref_clk);
            #1;
            chk(lpow, 2'h3);
            n = 0;
            while (mode_a === 1'b1 && n < 300)
            begin
                @(posedge ref_clk);
                #1;
                n++;
            end
            chk(n > 8 && n < 40, 1'b1);
            @(posedge ref_clk);
            #1;
            chk(lpow, 2'h1);
        end
        rd_reg(A_DISPCTL, d);
        chk(d[DC_ACT], 1'b1);
        // sleep: fosc stops, oscillator sources keep running
        wr_reg(A_PRESCALE, 8'h00);
        // source code 3 also runs from fosc
        wr_reg(A_DISPCTL, 8'h8B);
        sleep <= 1'b1;
        wt(700, n);
        wt(700, n);
        chk(n, 700);
        // mode B only from here: A high, B medium, duration zero
        wr_reg(A_LADDER, 8'hE0);
        // crystal assumed enabled by software beforehand
        for (i = 1; i < 3; i++)
        begin
            wr_reg(A_DISPCTL, 8'h88 | i);
            wt(5000, n);
            wt(5000, n);
            chk(n, frame_len(0, 8 * i));
        end
        chk(mode_a, 1'b0);
        chk(lpow, 2'h2);
        chk(seen, LAD_MED);
        // inactive module turns ladder off
        wr_reg(A_DISPCTL, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        chk(active, 1'b0);
        chk(lpow, 2'h0);
        chk(frames > 0, 1'b1);
        wrap_up;
    end
endmodule
